// ==== csp_top.sv ====
// Purpose: Code segment protection configuration with Avalon-MM registers
// Assumes: Single clock, synchronous active-high reset
// Notes:   Decoded outputs lag a config write by one edge; the flash gate reads the live bytes
//          Offsets 0x0, 0x4, 0x8 and 0xC; any other offset reads as zero and ignores writes
// Notes on behaviour
// - Boot write-protect 1 lets writes into the boot segment, 0 blocks them all.
// - Boot size code with low bits 11 means no boot segment exists.
// - Boot size codes 110 and 010 end the boot segment at 0x0007FE.
// - Boot size codes 101 and 001 give a 4K-word boot segment ending at 0x001FFE.
// - Boot size codes 100 and 000 give an 8K-word boot segment ending at 0x003FFE.
// - Boot RAM size code 10 is 128 bytes, 01 is 256 bytes and 00 is 1024 bytes.
// - Secure write-protect 1 lets writes into the secure segment, 0 blocks them all.
// - Secure size code with low bits 11 means no secure segment exists.
// - Secure codes 110 and 010 span from the boot end up to 0x001FFE.
// - Secure codes 101 and 001 span from the boot end up to 0x003FFE.
// - Secure codes 100 and 000 span from the boot end up to 0x007FFE.
// - The smallest variant has no secure segment, secure register or boot RAM field.
// - A changed setting takes effect at once, with no reset needed; the flash gate acts at once, but the decoded outputs follow one edge later.
`timescale 1ns/1ns
`include "csp_defines.svh"
module csp_top #(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic [3:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic               prog_wr_req,
  input  wire csp_pkg::csp_addr_t prog_wr_addr,
  output logic                    prog_wr_done,
  output logic                    prog_wr_commit,
  output logic                    prog_wr_blocked,
  output logic                    boot_present,
  output logic                    boot_high_sec,
  output csp_pkg::csp_addr_t      boot_last_addr,
  output logic                    secure_present,
  output logic                    secure_high_sec,
  output csp_pkg::csp_addr_t      secure_last_addr,
  output logic [10:0]             boot_ram_bytes
);
  import csp_pkg::*;

  // Configuration registers
  logic [7:0]     boot_segment_config_r;
  logic [7:0]     boot_segment_config_nxt;
  logic [7:0]     secure_segment_config_r;
  logic [7:0]     secure_segment_config_nxt;
  logic [7:0]     blocked_count_r;
  logic [7:0]     blocked_count_nxt;

  // Bus slave state
  csp_bus_state_t bus_state_r;
  csp_bus_state_t bus_state_nxt;
  logic [31:0]    rdata_r;
  logic [31:0]    rdata_nxt;
  logic           wait_r;
  logic           wait_nxt;

  // Registered decode outputs
  logic           boot_present_r;
  logic           boot_high_r;
  csp_addr_t      boot_last_r;
  logic           sec_present_r;
  logic           sec_high_r;
  csp_addr_t      sec_last_r;
  logic [10:0]    ram_bytes_r;

  // Field extraction
  wire logic           boot_wp_bit   = boot_segment_config_r[`CSP_WP_BIT];
  wire csp_size_code_t boot_size_security =
    boot_segment_config_r[`CSP_SIZE_MSB:`CSP_SIZE_LSB];
  wire logic [1:0]     boot_ram_size = boot_segment_config_r[`CSP_RAM_MSB:`CSP_RAM_LSB];
  wire logic           sec_wp_bit    = secure_segment_config_r[`CSP_WP_BIT];
  wire csp_size_code_t secure_size_security =
    secure_segment_config_r[`CSP_SIZE_MSB:`CSP_SIZE_LSB];

  // Segment decode, combinational from the live registers
  wire logic      bd_present;
  wire logic      bd_high;
  wire csp_addr_t bd_last;
  wire logic      sd_present_raw;
  wire logic      sd_high_raw;
  wire csp_addr_t sd_last;

  csp_seg_decode #(
    .KIND      (CSP_SEG_BOOT)
  ) u_boot_dec (
    .size_code (boot_size_security),
    .present   (bd_present),
    .high_sec  (bd_high),
    .last_addr (bd_last)
  );

  csp_seg_decode #(
    .KIND      (CSP_SEG_SECURE)
  ) u_sec_dec (
    .size_code (secure_size_security),
    .present   (sd_present_raw),
    .high_sec  (sd_high_raw),
    .last_addr (sd_last)
  );

  // Small variant has no secure segment at all
  wire logic sd_present = sd_present_raw & ~SMALL_VARIANT;
  wire logic sd_high    = sd_high_raw & ~SMALL_VARIANT;

  // Boot RAM size; code 11 and the small variant give no protected RAM
  function automatic logic [10:0] ram_code_bytes(input logic [1:0] code);
    logic [10:0] n;
    n = `CSP_RAM_NONE;
    unique case (code)
      2'h2: n = `CSP_RAM_128;
      2'h1: n = `CSP_RAM_256;
      2'h0: n = `CSP_RAM_1024;
      2'h3: n = `CSP_RAM_NONE;
    endcase
    return n;
  endfunction

  wire logic [10:0] ram_bytes_nxt = SMALL_VARIANT ? `CSP_RAM_NONE : ram_code_bytes(boot_ram_size);

  // Flash write gate uses the live registers, so a change acts at once
  wire logic gate_done;
  wire logic gate_commit;
  wire logic gate_blocked;

  csp_write_gate u_gate (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .wr_req        (prog_wr_req),
    .wr_addr       (prog_wr_addr),
    .boot_present  (bd_present),
    .boot_last     (bd_last),
    .boot_writable (boot_wp_bit),
    .sec_present   (sd_present),
    .sec_last      (sd_last),
    .sec_writable  (sec_wp_bit),
    .done_r        (gate_done),
    .commit_r      (gate_commit),
    .blocked_r     (gate_blocked)
  );

  // Bus decode
  wire logic req        = avs_read | avs_write;
  wire logic bus_idle   = (bus_state_r == CSP_BUS_IDLE);
  wire logic accept     = (bus_state_r == CSP_BUS_ANSWER);
  wire logic rd_take    = bus_idle & avs_read;
  wire logic sel_boot   = (avs_address == `CSP_OFS_BOOT_CFG);
  wire logic sel_sec    = (avs_address == `CSP_OFS_SEC_CFG) & ~SMALL_VARIANT;
  wire logic sel_status = (avs_address == `CSP_OFS_STATUS);
  wire logic sel_blk    = (avs_address == `CSP_OFS_BLOCKED);
  // Only lane 0 carries a register byte
  wire logic wr_any     = accept & avs_write;
  wire logic wr_lane0   = wr_any & avs_byteenable[0];
  wire logic wr_boot    = wr_lane0 & sel_boot;
  wire logic wr_sec     = wr_lane0 & sel_sec;
  wire logic clr_blk    = wr_lane0 & sel_blk;

  // Status word shows the decoded protection state
  wire logic [31:0] status_word = {
    5'h00,
    ram_bytes_r,
    8'h00,
    3'h0,
    SMALL_VARIANT,
    sec_high_r,
    sec_present_r,
    boot_high_r,
    boot_present_r
  };

  // Config and counter bytes sit in lane 0 of their words
  wire logic [31:0] word_boot = {24'h000000, boot_segment_config_r};
  wire logic [31:0] word_sec  = {24'h000000, secure_segment_config_r};
  wire logic [31:0] word_blk  = {24'h000000, blocked_count_r};

  // Unmapped and unimplemented offsets read as zero
  wire logic [31:0] read_mux =
    sel_boot   ? word_boot :
    sel_sec    ? word_sec :
    sel_status ? status_word :
    sel_blk    ? word_blk :
                 32'h00000000;

  // Writes land at the edge where waitrequest is seen low
  function automatic logic [7:0] cfg_next(input logic hit, input logic [31:0] wdata, input logic [7:0] cur);
    return hit ? wdata[7:0] : cur;
  endfunction

  assign boot_segment_config_nxt   = cfg_next(wr_boot, avs_writedata, boot_segment_config_r);
  assign secure_segment_config_nxt = cfg_next(wr_sec, avs_writedata, secure_segment_config_r);

  // A blocked write in the clearing cycle is still counted; the count
  // saturates so a flood of denied writes never wraps to a small number
  wire logic [7:0] blk_base = clr_blk ? 8'h00 : blocked_count_r;
  wire logic       blk_full = (blk_base == 8'hFF);
  wire logic [7:0] blk_step = blk_full ? 8'h00 : 8'h01;
  assign blocked_count_nxt =
    gate_blocked ? blk_base + blk_step : blk_base;

  // One idle cycle, then one answer cycle with waitrequest low
  assign bus_state_nxt =
    (bus_idle && req) ? CSP_BUS_ANSWER : CSP_BUS_IDLE;
  assign wait_nxt      = (bus_state_nxt != CSP_BUS_ANSWER);
  // Read data is caught on the taking edge, so it stands while waitrequest is low
  assign rdata_nxt =
    rd_take ? read_mux : rdata_r;

  // Two states: idle, then answer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_state_r <= CSP_BUS_IDLE;
    end else begin
      bus_state_r <= bus_state_nxt;
    end
  end

  // Waitrequest leaves reset high, so nothing is taken before the first idle edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= wait_nxt;
    end
  end

  // Read data holds until the next read, not only for the answer cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Erased configuration: no segments, everything writable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      boot_segment_config_r <= `CSP_CFG_RESET;
    end else begin
      boot_segment_config_r <= boot_segment_config_nxt;
    end
  end

  // Writes to the secure byte are dropped on the small variant
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      secure_segment_config_r <= `CSP_CFG_RESET;
    end else begin
      secure_segment_config_r <= secure_segment_config_nxt;
    end
  end

  // Counter clears on any lane-0 write to its offset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      blocked_count_r <= 8'h00;
    end else begin
      blocked_count_r <= blocked_count_nxt;
    end
  end

  // Decoded state is registered so every output leaves a flop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      boot_present_r <= 1'b0;
    end else begin
      boot_present_r <= bd_present;
    end
  end

  // Security level only means something while the segment exists
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      boot_high_r <= 1'b0;
    end else begin
      boot_high_r <= bd_high;
    end
  end

  // With no segment the end reads as the vector area end, never a stale size
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      boot_last_r <= `CSP_VEC_LAST;
    end else begin
      boot_last_r <= bd_last;
    end
  end

  // The small variant reports no secure segment whatever its byte holds
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sec_present_r <= 1'b0;
    end else begin
      sec_present_r <= sd_present;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sec_high_r <= 1'b0;
    end else begin
      sec_high_r <= sd_high;
    end
  end

  // Secure end stands alone; its start follows the boot end in the gate
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sec_last_r <= `CSP_VEC_LAST;
    end else begin
      sec_last_r <= sd_last;
    end
  end

  // Boot RAM size follows the live field one edge later
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ram_bytes_r <= `CSP_RAM_NONE;
    end else begin
      ram_bytes_r <= ram_bytes_nxt;
    end
  end

  assign avs_readdata     = rdata_r;
  assign avs_waitrequest  = wait_r;
  assign prog_wr_done     = gate_done;
  assign prog_wr_commit   = gate_commit;
  assign prog_wr_blocked  = gate_blocked;
  assign boot_present     = boot_present_r;
  assign boot_high_sec    = boot_high_r;
  assign boot_last_addr   = boot_last_r;
  assign secure_present   = sec_present_r;
  assign secure_high_sec  = sec_high_r;
  assign secure_last_addr = sec_last_r;
  assign boot_ram_bytes   = ram_bytes_r;
endmodule

// ==== csp_defines.svh ====
// Purpose: Offsets, field positions, reset values and segment limits
// Assumes: Byte addresses on a 32-bit register bus
// Notes:   Definitions only
`ifndef CSP_DEFINES_SVH
`define CSP_DEFINES_SVH
`define CSP_OFS_BOOT_CFG 4'h0
`define CSP_OFS_SEC_CFG  4'h4
`define CSP_OFS_STATUS   4'h8
`define CSP_OFS_BLOCKED  4'hC
`define CSP_WP_BIT       0
`define CSP_SIZE_LSB     1
`define CSP_SIZE_MSB     3
`define CSP_RAM_LSB      6
`define CSP_RAM_MSB      7
`define CSP_CFG_RESET    8'hFF
`define CSP_CODE_NONE    2'h3
`define CSP_END_1KW      24'h0007FE
`define CSP_END_4KW      24'h001FFE
`define CSP_END_8KW      24'h003FFE
`define CSP_END_16KW     24'h007FFE
`define CSP_VEC_LAST     24'h0001FE
`define CSP_RAM_NONE     11'h000
`define CSP_RAM_128      11'h080
`define CSP_RAM_256      11'h100
`define CSP_RAM_1024     11'h400
`endif

// ==== csp_pkg.sv ====
// Purpose: Shared types of the code segment protection block
// Assumes: Constants live in csp_defines.svh
// Notes:   Types only
package csp_pkg;
  typedef logic [23:0] csp_addr_t;
  typedef logic [2:0]  csp_size_code_t;
  typedef enum logic [1:0] {
    CSP_BUS_IDLE   = 2'b00,
    CSP_BUS_ANSWER = 2'b01
  } csp_bus_state_t;
  typedef enum logic {
    CSP_SEG_BOOT   = 1'b0,
    CSP_SEG_SECURE = 1'b1
  } csp_seg_kind_t;
endpackage

// ==== csp_seg_decode.sv ====
// Purpose: Decodes a segment size and security code
// Assumes: Top bit of the code selects standard (1) or high (0) security
// Notes:   Combinational
`timescale 1ns/1ns
`include "csp_defines.svh"
module csp_seg_decode #(
  parameter csp_pkg::csp_seg_kind_t KIND = csp_pkg::CSP_SEG_BOOT
) (
  input  wire csp_pkg::csp_size_code_t size_code,
  output logic                         present,
  output logic                         high_sec,
  output csp_pkg::csp_addr_t           last_addr
);
  import csp_pkg::*;

  function automatic csp_addr_t seg_last(input logic [1:0] low, input csp_seg_kind_t k);
    csp_addr_t a;
    a = `CSP_VEC_LAST;
    if (k == CSP_SEG_BOOT) begin
      unique case (low)
        2'h2:    a = `CSP_END_1KW;
        2'h1:    a = `CSP_END_4KW;
        2'h0:    a = `CSP_END_8KW;
        default: a = `CSP_VEC_LAST;
      endcase
    end else begin
      unique case (low)
        2'h2:    a = `CSP_END_4KW;
        2'h1:    a = `CSP_END_8KW;
        2'h0:    a = `CSP_END_16KW;
        default: a = `CSP_VEC_LAST;
      endcase
    end
    return a;
  endfunction

  // Low bits 11 mean no segment whatever the top bit
  assign present   = (size_code[1:0] != `CSP_CODE_NONE);
  assign high_sec  = present & ~size_code[2];
  assign last_addr = seg_last(size_code[1:0], KIND);
endmodule

// ==== csp_write_gate.sv ====
// Purpose: Grants or blocks a program flash write by segment protection
// Assumes: One request pulse, answered one edge later
// Notes:   Blocked writes still complete so the sequencer never stalls
`timescale 1ns/1ns
`include "csp_defines.svh"
module csp_write_gate (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               wr_req,
  input  wire csp_pkg::csp_addr_t wr_addr,
  input  wire logic               boot_present,
  input  wire csp_pkg::csp_addr_t boot_last,
  input  wire logic               boot_writable,
  input  wire logic               sec_present,
  input  wire csp_pkg::csp_addr_t sec_last,
  input  wire logic               sec_writable,
  output logic                    done_r,
  output logic                    commit_r,
  output logic                    blocked_r
);
  import csp_pkg::*;

  function automatic logic in_span(input csp_addr_t a, input csp_addr_t lo_ex, input csp_addr_t hi);
    return (a > lo_ex) && (a <= hi);
  endfunction

  // Secure space starts where the boot segment ends
  wire csp_addr_t sec_lo_ex = boot_present ? boot_last : `CSP_VEC_LAST;
  wire hit_boot = boot_present & in_span(wr_addr, `CSP_VEC_LAST, boot_last);
  wire hit_sec  = sec_present & in_span(wr_addr, sec_lo_ex, sec_last);
  wire deny     = (hit_boot & ~boot_writable) | (hit_sec & ~sec_writable);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_r    <= 1'b0;
      commit_r  <= 1'b0;
      blocked_r <= 1'b0;
    end else begin
      done_r    <= wr_req;
      commit_r  <= wr_req & ~deny;
      blocked_r <= wr_req & deny;
    end
  end
endmodule

// ==== csp_top_properties.sv ====
// Purpose: Concurrent checks on the csp_top ports
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every csp_top instance
`timescale 1ns/1ns
module csp_top_properties (
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic               avs_waitrequest,
  input wire logic               prog_wr_req,
  input wire logic               prog_wr_done,
  input wire logic               prog_wr_commit,
  input wire logic               prog_wr_blocked,
  input wire logic               boot_present,
  input wire logic               boot_high_sec,
  input wire csp_pkg::csp_addr_t boot_last_addr,
  input wire logic               secure_present,
  input wire logic               secure_high_sec,
  input wire csp_pkg::csp_addr_t secure_last_addr,
  input wire logic [10:0]        boot_ram_bytes
);
  import csp_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  AST_BUS_ANSWER:
    assert property ($rose(avs_read || avs_write) |-> s_answer) else $error("bus answer not on the second edge");
  AST_WAIT_PULSE:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
  AST_FLASH_DONE:
    assert property (prog_wr_req |=> prog_wr_done && (prog_wr_commit != prog_wr_blocked)) else $error("no done");
  AST_FLASH_IDLE:
    assert property (!prog_wr_req |=> !(prog_wr_done || prog_wr_commit || prog_wr_blocked)) else $error("stray pulse");
  AST_BOOT_NONE:
    assert property (!boot_present |-> boot_last_addr == 24'h0001FE && !boot_high_sec) else $error("boot none");
  AST_BOOT_END:
    assert property (boot_present |-> boot_last_addr inside {24'h0007FE, 24'h001FFE, 24'h003FFE}) else $error("boot end");
  AST_SEC_NONE:
    assert property (!secure_present |-> secure_last_addr == 24'h0001FE && !secure_high_sec) else $error("sec none");
  AST_SEC_END:
    assert property (secure_present |-> secure_last_addr inside {24'h001FFE, 24'h003FFE, 24'h007FFE}) else $error("sec end");
  AST_RAM_SIZE:
    assert property (boot_ram_bytes inside {11'h000, 11'h080, 11'h100, 11'h400}) else $error("ram size");
  // Decode follows a landed write one edge later; only that edge may move the outputs
  AST_CFG_HOLD:
    assert property (!$past(avs_write && !avs_waitrequest) |=> $stable(boot_last_addr) && $stable(secure_last_addr))
      else $error("decode moved without a write");
endmodule
bind csp_top csp_top_properties csp_top_properties_i (
  .clk_sys(clk_sys), .rst(rst), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .prog_wr_req(prog_wr_req), .prog_wr_done(prog_wr_done), .prog_wr_commit(prog_wr_commit),
  .prog_wr_blocked(prog_wr_blocked), .boot_present(boot_present), .boot_high_sec(boot_high_sec),
  .boot_last_addr(boot_last_addr), .secure_present(secure_present), .secure_high_sec(secure_high_sec),
  .secure_last_addr(secure_last_addr), .boot_ram_bytes(boot_ram_bytes));

// ==== csp_top_test.sv ====
// Purpose: Self-checking bench for csp_top
// Assumes: Avalon answer on the second edge, flash answer one edge after request
// Notes:   Expectations come from the size tables, not from the design
`timescale 1ns/1ns
module csp_top_test;
  import csp_pkg::*;
  logic        clk_sys, rst, avs_read, avs_write, avs_waitrequest, prog_wr_req;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        prog_wr_done, prog_wr_commit, prog_wr_blocked, boot_present, boot_high_sec;
  logic        secure_present, secure_high_sec;
  csp_addr_t   prog_wr_addr, boot_last_addr, secure_last_addr;
  logic [10:0] boot_ram_bytes;
  logic [31:0] sm_readdata, sm_q;
  logic        sm_secure_present;
  logic [10:0] sm_ram_bytes;
  int          n_mismatch, checked, cyc;
  logic [10:0] ram_t [4] = '{11'h400, 11'h100, 11'h080, 11'h000};
  csp_top csp_top_i (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .prog_wr_req(prog_wr_req),
    .prog_wr_addr(prog_wr_addr), .prog_wr_done(prog_wr_done), .prog_wr_commit(prog_wr_commit),
    .prog_wr_blocked(prog_wr_blocked), .boot_present(boot_present), .boot_high_sec(boot_high_sec),
    .boot_last_addr(boot_last_addr), .secure_present(secure_present), .secure_high_sec(secure_high_sec),
    .secure_last_addr(secure_last_addr), .boot_ram_bytes(boot_ram_bytes));
  // Smallest variant sees the same stimulus
  csp_top #(.SMALL_VARIANT(1'b1)) csp_top_small_i (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(sm_readdata), .avs_waitrequest(), .prog_wr_req(prog_wr_req), .prog_wr_addr(prog_wr_addr),
    .prog_wr_done(), .prog_wr_commit(), .prog_wr_blocked(), .boot_present(), .boot_high_sec(),
    .boot_last_addr(), .secure_present(sm_secure_present), .secure_high_sec(), .secure_last_addr(),
    .boot_ram_bytes(sm_ram_bytes));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task stop_test;
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // A run this short never needs more than a few hundred cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      stop_test;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    q = avs_readdata;
    sm_q = sm_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task settle;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task fl(input csp_addr_t a, input logic ok);
    @(posedge clk_sys);
    prog_wr_req <= 1'b1;
    prog_wr_addr <= a;
    @(posedge clk_sys);
    prog_wr_req <= 1'b0;
    @(negedge clk_sys);
    chk({prog_wr_done, prog_wr_commit, prog_wr_blocked}, {1'b1, ok, !ok});
  endtask
  function csp_addr_t exp_end(input logic [1:0] c, input logic sec);
    case (c)
      2'h3: exp_end = 24'h0001FE;
      2'h2: exp_end = sec ? 24'h001FFE : 24'h0007FE;
      2'h1: exp_end = sec ? 24'h003FFE : 24'h001FFE;
      default: exp_end = sec ? 24'h007FFE : 24'h003FFE;
    endcase
  endfunction
  task t_reset;
    @(negedge clk_sys);
    chk(avs_waitrequest, 32'h1);
    chk(boot_last_addr, 32'h1FE);
    bus(1'b0, 4'h0, 8'h00, 4'hF);
    chk(q, 32'hFF);
    bus(1'b0, 4'h4, 8'h00, 4'hF);
    chk(q, 32'hFF);
    chk(sm_q, 32'h0);
  endtask
  task t_sizes;
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 4'h0, {4'h3, c[2:0], 1'b1}, 4'h1);
      bus(1'b1, 4'h4, {4'h0, c[2:0], 1'b1}, 4'h1);
      settle;
      chk({boot_present, boot_high_sec}, {c[1:0] != 2'h3, c[1:0] != 2'h3 && !c[2]});
      chk(boot_last_addr, exp_end(c[1:0], 1'b0));
      chk({secure_present, secure_high_sec}, {c[1:0] != 2'h3, c[1:0] != 2'h3 && !c[2]});
      chk(secure_last_addr, exp_end(c[1:0], 1'b1));
      chk(sm_secure_present, 32'h0);
    end
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, 4'h0, {r[1:0], 6'h3F}, 4'h1);
      settle;
      chk(boot_ram_bytes, ram_t[r]);
      chk(sm_ram_bytes, 32'h0);
    end
  endtask
  task t_protect;
    bus(1'b1, 4'h0, 8'h3C, 4'h1);
    bus(1'b1, 4'h4, 8'h0A, 4'h1);
    bus(1'b0, 4'h4, 8'h00, 4'hF);
    chk(q, 32'h0A);
    chk(sm_q, 32'h0);
    settle;
    fl(24'h000400, 1'b0);
    fl(24'h000100, 1'b1);
    fl(24'h0007FE, 1'b0);
    fl(24'h000800, 1'b0);
    fl(24'h002000, 1'b0);
    fl(24'h003FFE, 1'b0);
    fl(24'h004000, 1'b1);
    bus(1'b0, 4'hC, 8'h00, 4'hF);
    chk(q, 32'h5);
    bus(1'b0, 4'h8, 8'h00, 4'hF);
    chk(q, 32'h04000005);
    chk(sm_q, 32'h00000011);
    bus(1'b0, 4'h2, 8'h00, 4'hF);
    chk(q, 32'h0);
    bus(1'b1, 4'hC, 8'h00, 4'h1);
    bus(1'b0, 4'hC, 8'h00, 4'hF);
    chk(q, 32'h0);
    bus(1'b1, 4'h0, 8'h3D, 4'h1);
    bus(1'b1, 4'h4, 8'h0B, 4'h1);
    fl(24'h000400, 1'b1);
    fl(24'h002000, 1'b1);
    bus(1'b1, 4'h0, 8'h3C, 4'h0);
    settle;
    fl(24'h000400, 1'b1);
  endtask
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    prog_wr_req = 1'b0;
    prog_wr_addr = 24'h000000;
    n_mismatch = 0;
    checked = 0;
    cyc = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_sizes;
    t_protect;
    stop_test;
  end
endmodule
